/* inc/vam_pkg.sv */
package vam_pkg;
  // Register byte offsets
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STATE = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

  // Source selection codes
  localparam logic [1:0] SRC_A = 2'h0;
  localparam logic [1:0] SRC_B = 2'h1;
  localparam logic [1:0] SRC_BOTH = 2'h2;
  localparam logic [1:0] SRC_SUM = 2'h3;

  // Command opcodes in the command register low nibble
  localparam logic [3:0] OP_SOURCE = 4'h1;
  localparam logic [3:0] OP_INVERT = 4'h2;
  localparam logic [3:0] OP_EYE_ON = 4'h3;
  localparam logic [3:0] OP_EYE_OFF = 4'h4;
  localparam logic [3:0] OP_AVG_SET = 4'h5;
  localparam logic [3:0] OP_AVG_OFF = 4'h6;
  localparam logic [3:0] OP_AVG_C4 = 4'h7;
  localparam logic [3:0] OP_RS_SET = 4'h8;
  localparam logic [3:0] OP_RS_OFF = 4'h9;
  localparam logic [3:0] OP_XY_ON = 4'ha;
  localparam logic [3:0] OP_XY_OFF = 4'hb;
  localparam logic [3:0] OP_LOWRES_ON = 4'hc;
  localparam logic [3:0] OP_LOWRES_OFF = 4'hd;

  // Averaging code k means C = 2**k; 0 is off
  localparam logic [2:0] AVG_OFF = 3'h0;
  localparam logic [2:0] AVG_C4 = 3'h2;
  localparam logic [2:0] AVG_MAX = 3'h6;
  // Repeat sampling code k means M = 2**k; 0 is off
  localparam logic [2:0] RS_OFF = 3'h0;
  localparam logic [2:0] RS_MAX = 3'h5;

  // Last point index of each record; the length in measured points is one more
  localparam logic [11:0] PTS_EYE_LAST = 12'hfff;
  localparam logic [11:0] PTS_NORM_LAST = 12'h1ff;

  // Interrupt status bits
  localparam int IRQ_BITS = 5;
  localparam int IRQ_XY_CANCEL = 0;
  localparam int IRQ_EYE_CANCEL = 1;
  localparam int IRQ_AVG_CANCEL = 2;
  localparam int IRQ_RS_CANCEL = 3;
  localparam int IRQ_REC_DONE = 4;

  // State register fields
  localparam int ST_INV_A = 2;
  localparam int ST_INV_B = 3;
  localparam int ST_XY = 4;
  localparam int ST_EYE = 5;
  localparam int ST_LOWRES = 6;
  localparam int ST_AVG_LO = 8;
  localparam int ST_RS_LO = 12;
  localparam int ST_ZOOM_BLOCK = 16;
  localparam int ST_LOOP_EN = 17;

  localparam int SAMPLE_W = 8;
  localparam int MEM_W = 10;
endpackage : vam_pkg

/* verilog/vam_ctrl.sv */
`timescale 1ns/1ps
module vam_ctrl (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic signed [7:0] a_sample,
  input wire logic signed [7:0] b_sample,
  input wire logic sample_strobe,
  output logic feedback_loop_en,
  output logic mem_we,
  output logic [11:0] mem_addr,
  output logic signed [9:0] mem_data_a,
  output logic signed [9:0] mem_data_b,
  output logic mem_a_en,
  output logic mem_b_en,
  output logic record_done,
  output logic stepped_horiz_zoom_block,
  output logic [2:0] smoothing_code,
  output logic [2:0] repeat_sample_code
);

  typedef enum logic [1:0] {
    VAM_IDLE = 2'b01,
    VAM_ACK = 2'b10
  } vam_bus_type;

  vam_bus_type bus_state;
  logic [1:0] source;
  logic inv_a;
  logic inv_b;
  logic xy_mode;
  logic eye_diagram_mode;
  logic lowres_mode;
  logic [4:0] irq_stat;
  logic [4:0] irq_mask;
  logic [4:0] notice;
  logic [4:0] rs_count;
  logic [4:0] rs_last;
  logic [11:0] next_addr;
  logic signed [9:0] a_val;
  logic signed [9:0] b_val;
  logic cmd_go;
  logic [3:0] opcode;
  logic [3:0] arg;
  logic acc_go;
  logic point_go;

  assign acc_go = (bus_state == VAM_ACK);
  assign cmd_go = acc_go && avs_write && (avs_address == vam_pkg::ADDR_CMD);
  assign opcode = avs_writedata[3:0];
  assign arg = avs_writedata[7:4];

  // Bus slave: waitrequest drops for one cycle per access
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_state <= VAM_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        VAM_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= VAM_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        VAM_ACK: begin
          bus_state <= VAM_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state <= VAM_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read data loaded as waitrequest falls, held until next read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_state == VAM_IDLE && avs_read) begin
      avs_readdata <= 32'h0000_0000;
      case (avs_address)
        vam_pkg::ADDR_STATE: begin
          avs_readdata[1:0] <= source;
          avs_readdata[vam_pkg::ST_INV_A] <= inv_a;
          avs_readdata[vam_pkg::ST_INV_B] <= inv_b;
          avs_readdata[vam_pkg::ST_XY] <= xy_mode;
          avs_readdata[vam_pkg::ST_EYE] <= eye_diagram_mode;
          avs_readdata[vam_pkg::ST_LOWRES] <= lowres_mode;
          avs_readdata[vam_pkg::ST_AVG_LO +: 3] <= smoothing_code;
          avs_readdata[vam_pkg::ST_RS_LO +: 3] <= repeat_sample_code;
          avs_readdata[vam_pkg::ST_ZOOM_BLOCK] <= stepped_horiz_zoom_block;
          avs_readdata[vam_pkg::ST_LOOP_EN] <= feedback_loop_en;
        end
        vam_pkg::ADDR_IRQ_STAT: begin
          avs_readdata[4:0] <= irq_stat;
        end
        vam_pkg::ADDR_IRQ_MASK: begin
          avs_readdata[4:0] <= irq_mask;
        end
        default: begin
          avs_readdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Source and inversion; single-channel or sum choice cancels X-Y
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      source <= vam_pkg::SRC_A;
      inv_a <= 1'b0;
      inv_b <= 1'b0;
      xy_mode <= 1'b0;
    end else if (cmd_go) begin
      case (opcode)
        vam_pkg::OP_SOURCE: begin
          source <= arg[1:0];
          if (arg[1:0] != vam_pkg::SRC_BOTH) begin
            xy_mode <= 1'b0;
          end
        end
        vam_pkg::OP_INVERT: begin
          if (arg[0]) begin
            inv_b <= arg[1];
          end else begin
            inv_a <= arg[1];
          end
        end
        vam_pkg::OP_XY_ON: begin
          // X-Y needs both channels shown separately
          if (source == vam_pkg::SRC_BOTH) begin
            xy_mode <= 1'b1;
          end
        end
        vam_pkg::OP_XY_OFF: begin
          xy_mode <= 1'b0;
        end
        default: begin
          xy_mode <= xy_mode;
        end
      endcase
    end
  end

  // Processing modes with mutual exclusion
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      eye_diagram_mode <= 1'b0;
      lowres_mode <= 1'b0;
      smoothing_code <= vam_pkg::AVG_OFF;
      repeat_sample_code <= vam_pkg::RS_OFF;
    end else if (cmd_go) begin
      case (opcode)
        vam_pkg::OP_EYE_ON: begin
          eye_diagram_mode <= 1'b1;
          smoothing_code <= vam_pkg::AVG_OFF;
          repeat_sample_code <= vam_pkg::RS_OFF;
        end
        vam_pkg::OP_EYE_OFF: begin
          eye_diagram_mode <= 1'b0;
        end
        vam_pkg::OP_AVG_SET: begin
          // Out-of-range code ignored, never treated as off
          if (arg[2:0] != vam_pkg::AVG_OFF &&
              arg[2:0] <= vam_pkg::AVG_MAX) begin
            smoothing_code <= arg[2:0];
            eye_diagram_mode <= 1'b0;
            lowres_mode <= 1'b0;
          end
        end
        vam_pkg::OP_AVG_C4: begin
          smoothing_code <= vam_pkg::AVG_C4;
          eye_diagram_mode <= 1'b0;
          lowres_mode <= 1'b0;
        end
        vam_pkg::OP_AVG_OFF: begin
          smoothing_code <= vam_pkg::AVG_OFF;
        end
        vam_pkg::OP_RS_SET: begin
          if (arg[2:0] != vam_pkg::RS_OFF &&
              arg[2:0] <= vam_pkg::RS_MAX) begin
            repeat_sample_code <= arg[2:0];
            eye_diagram_mode <= 1'b0;
          end
        end
        vam_pkg::OP_RS_OFF: begin
          repeat_sample_code <= vam_pkg::RS_OFF;
        end
        vam_pkg::OP_LOWRES_ON: begin
          // Low resolution cannot coexist with averaging
          if (smoothing_code == vam_pkg::AVG_OFF) begin
            lowres_mode <= 1'b1;
          end
        end
        vam_pkg::OP_LOWRES_OFF: begin
          lowres_mode <= 1'b0;
        end
        default: begin
          // Other commands leave the held constants alone
          smoothing_code <= smoothing_code;
        end
      endcase
    end
  end

  // Conflict notices
  always_comb begin
    notice = 5'h00;
    if (cmd_go) begin
      case (opcode)
        vam_pkg::OP_SOURCE: begin
          notice[vam_pkg::IRQ_XY_CANCEL] = xy_mode &&
            (source == vam_pkg::SRC_BOTH) &&
            (arg[1:0] != vam_pkg::SRC_BOTH);
        end
        vam_pkg::OP_EYE_ON: begin
          notice[vam_pkg::IRQ_EYE_CANCEL] =
            (smoothing_code != vam_pkg::AVG_OFF) ||
            (repeat_sample_code != vam_pkg::RS_OFF);
        end
        vam_pkg::OP_AVG_SET: begin
          notice[vam_pkg::IRQ_AVG_CANCEL] = (eye_diagram_mode ||
            lowres_mode) && (arg[2:0] != vam_pkg::AVG_OFF) &&
            (arg[2:0] <= vam_pkg::AVG_MAX);
        end
        vam_pkg::OP_AVG_C4: begin
          notice[vam_pkg::IRQ_AVG_CANCEL] =
            eye_diagram_mode || lowres_mode;
        end
        vam_pkg::OP_RS_SET: begin
          notice[vam_pkg::IRQ_RS_CANCEL] = eye_diagram_mode &&
            (arg[2:0] != vam_pkg::RS_OFF) &&
            (arg[2:0] <= vam_pkg::RS_MAX);
        end
        default: begin
          notice = 5'h00;
        end
      endcase
    end
    notice[vam_pkg::IRQ_REC_DONE] = point_go && mem_we_pending_last();
  end

  // Record end is seen when the point counter wraps
  function automatic logic mem_we_pending_last();
    mem_we_pending_last = (next_addr == 12'h000);
  endfunction : mem_we_pending_last

  // Sticky status, write one to clear; a new event wins over its clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_stat <= 5'h00;
      irq_mask <= 5'h00;
      irq <= 1'b0;
    end else begin
      if (acc_go && avs_write && avs_address == vam_pkg::ADDR_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~avs_writedata[4:0]) | notice;
      end else begin
        irq_stat <= irq_stat | notice;
      end
      if (acc_go && avs_write && avs_address == vam_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= avs_writedata[4:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Eye mode opens the sampling feedback loop
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      feedback_loop_en <= 1'b1;
    end else begin
      feedback_loop_en <= !eye_diagram_mode;
    end
  end

  // Negate in 10 bits so that -128 stays exact
  assign a_val = inv_a ? -10'(a_sample) : 10'(a_sample);
  assign b_val = inv_b ? -10'(b_sample) : 10'(b_sample);

  // Repeat sampling: M samples per point, the last one is kept
  assign rs_last = 5'((6'h01 << repeat_sample_code) - 6'h01);
  // Count left over from a larger factor still ends the point
  assign point_go = sample_strobe && (rs_count >= rs_last);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rs_count <= 5'h00;
    end else if (sample_strobe) begin
      if (rs_count >= rs_last) begin
        rs_count <= 5'h00;
      end else begin
        rs_count <= rs_count + 5'h01;
      end
    end
  end

  // Point counter: 4096 measured points in eye mode, 512 otherwise
  always_comb begin
    next_addr = mem_addr + 12'h001;
    if (eye_diagram_mode) begin
      if (mem_addr >= vam_pkg::PTS_EYE_LAST) begin
        next_addr = 12'h000;
      end
    end else if (mem_addr >= vam_pkg::PTS_NORM_LAST) begin
      next_addr = 12'h000;
    end
  end

  // Memory write port
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mem_we <= 1'b0;
      mem_addr <= 12'h000;
      mem_data_a <= 10'sh000;
      mem_data_b <= 10'sh000;
      mem_a_en <= 1'b0;
      mem_b_en <= 1'b0;
      record_done <= 1'b0;
      stepped_horiz_zoom_block <= 1'b0;
    end else begin
      mem_we <= point_go;
      record_done <= 1'b0;
      if (point_go) begin
        mem_addr <= next_addr;
        case (source)
          vam_pkg::SRC_A: begin
            mem_data_a <= a_val;
            mem_data_b <= 10'sh000;
            mem_a_en <= 1'b1;
            mem_b_en <= 1'b0;
          end
          vam_pkg::SRC_B: begin
            mem_data_a <= 10'sh000;
            mem_data_b <= b_val;
            mem_a_en <= 1'b0;
            mem_b_en <= 1'b1;
          end
          vam_pkg::SRC_SUM: begin
            mem_data_a <= a_val + b_val;
            mem_data_b <= 10'sh000;
            mem_a_en <= 1'b1;
            mem_b_en <= 1'b0;
          end
          default: begin
            mem_data_a <= a_val;
            mem_data_b <= b_val;
            mem_a_en <= 1'b1;
            mem_b_en <= 1'b1;
          end
        endcase
        if (next_addr == 12'h000) begin
          record_done <= 1'b1;
          stepped_horiz_zoom_block <= eye_diagram_mode;
        end
      end
    end
  end

endmodule : vam_ctrl

/* testbench/vam_checker.sv */
`timescale 1ns/1ps
module vam_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic sample_strobe,
  input wire logic feedback_loop_en,
  input wire logic mem_we,
  input wire logic [11:0] mem_addr,
  input wire logic record_done,
  input wire logic stepped_horiz_zoom_block,
  input wire logic [2:0] smoothing_code,
  input wire logic [2:0] repeat_sample_code
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [11:0] last_addr;
  // Wrap left out: a mode change may cut a record short
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      last_addr <= 12'h000;
    end else if (mem_we) begin
      last_addr <= mem_addr;
    end
  end
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  bus_pulse_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  eye_entry_a: assert property (
    $fell(feedback_loop_en) |-> smoothing_code == 3'h0
      && repeat_sample_code == 3'h0)
    else $error("eye mode with processing on");
  avg_loop_a: assert property (
    smoothing_code != 3'h0 |=> feedback_loop_en)
    else $error("averaging with loop off");
  rs_loop_a: assert property (
    repeat_sample_code != 3'h0 |=> feedback_loop_en)
    else $error("repeat sampling with loop off");
  point_cause_a: assert property (
    mem_we |-> $past(sample_strobe))
    else $error("write without strobe");
  single_point_a: assert property (
    repeat_sample_code == 3'h0 && sample_strobe |=> mem_we)
    else $error("strobe lost");
  addr_step_a: assert property (
    mem_we && mem_addr != 12'h000 |-> mem_addr == last_addr + 12'h001)
    else $error("address skipped");
  done_wrap_a: assert property (
    record_done |-> mem_we && mem_addr == 12'h000)
    else $error("done off the wrap");
  zoom_latch_a: assert property (
    $changed(stepped_horiz_zoom_block) |-> record_done)
    else $error("zoom flag moved mid-record");
endmodule : vam_checker

bind vam_ctrl vam_checker u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .sample_strobe(sample_strobe), .feedback_loop_en(feedback_loop_en),
  .mem_we(mem_we), .mem_addr(mem_addr), .record_done(record_done),
  .stepped_horiz_zoom_block(stepped_horiz_zoom_block),
  .smoothing_code(smoothing_code),
  .repeat_sample_code(repeat_sample_code)
);

/* testbench/vam_acq_model.sv */
`timescale 1ns/1ps
module vam_acq_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mem_we,
  input wire logic signed [9:0] mem_data_a,
  input wire logic signed [9:0] mem_data_b,
  input wire logic mem_a_en,
  input wire logic mem_b_en,
  input wire logic record_done,
  output int wr_count,
  output int rec_len,
  output logic signed [9:0] last_a,
  output logic signed [9:0] last_b,
  output logic [1:0] last_en
);
  int run;
  // Stores only; record length counted between wraps
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_count <= 0;
      rec_len <= 0;
      run <= 0;
    end else if (mem_we) begin
      wr_count <= wr_count + 1;
      last_a <= mem_data_a;
      last_b <= mem_data_b;
      last_en <= {mem_a_en, mem_b_en};
      run <= record_done ? 0 : run + 1;
      rec_len <= record_done ? run + 1 : rec_len;
    end
  end
endmodule : vam_acq_model

/* testbench/tb_vertical_acquisition_mode_control.sv */
`timescale 1ns/1ps
module tb_vertical_acquisition_mode_control;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic signed [7:0] a_sample = 8'h00;
  logic signed [7:0] b_sample = 8'h00;
  logic sample_strobe = 1'b0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, irq, feedback_loop_en, mem_we, mem_a_en, mem_b_en;
  logic record_done, stepped_horiz_zoom_block;
  logic [11:0] mem_addr;
  logic signed [9:0] mem_data_a, mem_data_b, last_a, last_b;
  logic [2:0] smoothing_code, repeat_sample_code;
  logic [1:0] last_en;
  logic [31:0] rnd = 32'h9663f6c4;
  int failures = 0;
  int tests_run = 0;
  int wr_count, rec_len, i, d, k, w;
  int src, ia, ib, xy, eye, lr, avg, rs, zm, stat, msk;

  always #4 mclk = ~mclk;

  vam_ctrl u_dut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .a_sample(a_sample), .b_sample(b_sample),
    .sample_strobe(sample_strobe), .feedback_loop_en(feedback_loop_en),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_data_a(mem_data_a),
    .mem_data_b(mem_data_b), .mem_a_en(mem_a_en), .mem_b_en(mem_b_en),
    .record_done(record_done),
    .stepped_horiz_zoom_block(stepped_horiz_zoom_block),
    .smoothing_code(smoothing_code), .repeat_sample_code(repeat_sample_code));
  vam_acq_model u_mem (.mclk(mclk), .sys_rst(sys_rst), .mem_we(mem_we),
    .mem_data_a(mem_data_a), .mem_data_b(mem_data_b), .mem_a_en(mem_a_en),
    .mem_b_en(mem_b_en), .record_done(record_done), .wr_count(wr_count),
    .rec_len(rec_len), .last_a(last_a), .last_b(last_b), .last_en(last_en));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int inv(input logic [7:0] v, input int f);
    return f ? -int'($signed(v)) : int'($signed(v));
  endfunction : inv
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic bus(input logic wr, input logic [3:0] ad, input int wd);
    int n;
    @(posedge mclk);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    for (n = 0; n < 20 && avs_waitrequest; n++) begin
      @(posedge mclk);
    end
    if (n == 20) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic cmd(input logic [3:0] op, input logic [3:0] ag);
    int k;
    bus(1'b1, vam_pkg::ADDR_CMD, {24'h0, ag, op});
    k = (op == vam_pkg::OP_AVG_C4) ? 2 : ag[2:0];
    case (op)
      vam_pkg::OP_SOURCE: begin
        stat |= (xy && ag[1:0] != 2) ? 1 : 0;
        xy = (ag[1:0] == 2) ? xy : 0;
        src = ag[1:0];
      end
      vam_pkg::OP_INVERT: begin
        ia = ag[0] ? ia : ag[1];
        ib = ag[0] ? ag[1] : ib;
      end
      vam_pkg::OP_EYE_ON: begin
        stat |= (avg || rs) ? 2 : 0;
        avg = 0;
        rs = 0;
        eye = 1;
      end
      vam_pkg::OP_AVG_SET, vam_pkg::OP_AVG_C4: if (k >= 1 && k <= 6) begin
        stat |= (eye || lr) ? 4 : 0;
        eye = 0;
        lr = 0;
        avg = k;
      end
      vam_pkg::OP_RS_SET: if (ag[2:0] >= 1 && ag[2:0] <= 5) begin
        stat |= eye ? 8 : 0;
        eye = 0;
        rs = ag[2:0];
      end
      vam_pkg::OP_EYE_OFF: eye = 0;
      vam_pkg::OP_AVG_OFF: avg = 0;
      vam_pkg::OP_RS_OFF: rs = 0;
      vam_pkg::OP_XY_ON: xy = (src == 2) ? 1 : xy;
      vam_pkg::OP_XY_OFF: xy = 0;
      vam_pkg::OP_LOWRES_ON: lr = avg ? lr : 1;
      vam_pkg::OP_LOWRES_OFF: lr = 0;
      default: ;
    endcase
  endtask : cmd
  task automatic check_all();
    bus(1'b0, vam_pkg::ADDR_STATE, 0);
    chk(rd, {14'h0, !eye, zm[0], 1'b0, rs[2:0], 1'b0, avg[2:0], 1'b0,
      lr[0], eye[0], xy[0], ib[0], ia[0], src[1:0]});
    bus(1'b0, vam_pkg::ADDR_IRQ_STAT, 0);
    chk(rd, stat);
    chk(irq, |(stat & msk));
    chk(smoothing_code, avg);
    chk(repeat_sample_code, rs);
  endtask : check_all
  task automatic pulse(input logic [7:0] a, input logic [7:0] b);
    int c;
    c = wr_count;
    @(posedge mclk);
    a_sample <= a;
    b_sample <= b;
    sample_strobe <= 1'b1;
    @(posedge mclk);
    sample_strobe <= 1'b0;
    repeat (2) @(posedge mclk);
    d = wr_count - c;
    if (d == 1 && src != 1) begin
      chk(32'(last_a), inv(a, ia) + (src == 3 ? inv(b, ib) : 0));
    end
    if (d == 1) begin
      chk(32'(last_b), (src == 1 || src == 2) ? inv(b, ib) : 0);
      chk(last_en, {src != 1, src == 1 || src == 2});
    end
  endtask : pulse
  task automatic burst(input int n);
    @(posedge mclk);
    sample_strobe <= 1'b1;
    repeat (n) @(posedge mclk);
    sample_strobe <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : burst

  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    check_all();
    bus(1'b0, 4'h2, 0);
    chk(rd, 0);
    bus(1'b0, vam_pkg::ADDR_CMD, 0);
    chk(rd, 0);
    $display("reset test done");
    for (i = 0; i < 300; i++) begin
      rnd = lfsr(rnd);
      cmd(rnd[3:0], rnd[7:4]);
      msk = rnd[12:8];
      bus(1'b1, vam_pkg::ADDR_IRQ_MASK, msk);
      check_all();
      bus(1'b1, vam_pkg::ADDR_IRQ_STAT, rnd[20:16]);
      stat &= ~rnd[20:16];
    end
    $display("command test done");
    cmd(vam_pkg::OP_RS_OFF, 4'h0);
    for (i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      cmd(vam_pkg::OP_SOURCE, rnd[3:0]);
      cmd(vam_pkg::OP_INVERT, rnd[7:4]);
      pulse(rnd[15:8], rnd[23:16]);
      chk(d, 1);
    end
    $display("data path test done");
    cmd(vam_pkg::OP_SOURCE, 4'h0);
    cmd(vam_pkg::OP_RS_SET, 4'h2);
    k = 0;
    w = 0;
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      pulse(rnd[7:0], rnd[15:8]);
      k++;
      if (d == 1) begin
        w++;
        if (w > 1) begin
          chk(k, 4);
        end
        k = 0;
      end
    end
    chk(w, 2);
    $display("repeat sampling test done");
    cmd(vam_pkg::OP_EYE_ON, 4'h0);
    repeat (2) @(posedge mclk);
    chk(feedback_loop_en, 1'b0);
    burst(8300);
    chk(rec_len, 4096);
    chk(stepped_horiz_zoom_block, 1'b1);
    zm = 1;
    stat |= 16;
    check_all();
    cmd(vam_pkg::OP_EYE_OFF, 4'h0);
    burst(1100);
    chk(rec_len, 512);
    chk(stepped_horiz_zoom_block, 1'b0);
    chk(feedback_loop_en, 1'b1);
    zm = 0;
    check_all();
    $display("record test done");
    end_sim();
  end
endmodule : tb_vertical_acquisition_mode_control
